//--- xfer_err_pkg.sv
// Purpose: Shared codes, field layouts and timing for the error reporter
// Assumes: 20 MHz system clock
// Notes: Codes are 16-bit values placed in status words
package xfer_err_pkg;
  // ========================================
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int WR_TIMEOUT_MS = 100;
  localparam int WR_TIMEOUT_CYCLES = WR_TIMEOUT_MS * (CLK_HZ / 1000);
  // ========================================
  // Common codes
  localparam logic [15:0] C_NONE = 16'h0000;
  localparam logic [15:0] C_WORDS = 16'h8221;
  localparam logic [15:0] C_SRC_AREA = 16'h8222;
  localparam logic [15:0] C_SRC_WORD = 16'h8223;
  localparam logic [15:0] C_DST_AREA = 16'h8224;
  localparam logic [15:0] C_DST_WORD = 16'h8225;
  localparam logic [15:0] C_SETUP_ONLY = 16'h8226;
  localparam logic [15:0] C_WR_TIMEOUT = 16'h8227;
  localparam logic [15:0] C_SLV_DATA = 16'h8228;
  localparam logic [15:0] C_BUS_ERR = 16'h8229;
  localparam logic [15:0] C_SLV_ERR = 16'h822a;
  localparam logic [15:0] C_SAVE_BLOCK = 16'h8230;
  // Data check warning: high byte by class, low byte is offset
  localparam logic [7:0] C_CHK_COMMON = 8'h90;
  localparam logic [7:0] C_CHK_AXIS = 8'h91;
  localparam logic [7:0] C_CHK_TASK = 8'h92;
  localparam logic [1:0] PCLASS_COMMON = 2'h0;
  localparam logic [1:0] PCLASS_AXIS = 2'h1;
  // ========================================
  // Axis and task codes
  localparam logic [15:0] C_SERVO_WARN = 16'hd00f;
  localparam logic [15:0] C_CMD_OVF = 16'he027;
  localparam logic [15:0] C_FB_OVF = 16'he028;
  localparam logic [15:0] C_TEACH_ADDR = 16'hed00;
  localparam logic [15:0] C_TEACH_BLOCK = 16'hed01;
  localparam logic [15:0] C_TEACH_OVF = 16'hed02;
  // ========================================
  // Data-write request carried from the host
  typedef struct packed {
    logic [15:0] words;
    logic [7:0] src_area;
    logic [15:0] src_word;
    logic [7:0] dst_area;
    logic [15:0] dst_word;
    logic slave_param;
    logic setup_eff;
    logic [1:0] pclass;
    logic [7:0] poffset;
    logic data_ok;
  } wr_req_t;
  typedef enum logic {WS_IDLE = 1'b0, WS_BUSY = 1'b1} wr_state_t;
endpackage

//--- position_tracker.sv
// Purpose: Signed 32-bit present position with overflow latch
// Assumes: One step per cycle at most
// Notes: Update stops once the range is left
`timescale 1ns/1ns
`default_nettype none
module position_tracker (
  input wire logic clk,
  input wire logic rst,
  input wire logic step_v,
  input wire logic [31:0] step,
  input wire logic clr,
  input wire logic [31:0] clr_val,
  output logic [31:0] pos_q,
  output logic ovf_q
);
  logic [31:0] pos_d;
  logic ovf_d;
  logic [32:0] sum;
  // ========================================
  // Next position
  always_comb begin
    sum = {pos_q[31], pos_q} + {step[31], step};
    pos_d = pos_q;
    ovf_d = ovf_q;
    if (clr) begin
      pos_d = clr_val;
      ovf_d = 1'b0;
    end else if (step_v && !ovf_q) begin
      if (sum[32] != sum[31]) begin
        ovf_d = 1'b1;
      end else begin
        pos_d = sum[31:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_q <= 32'h0000_0000;
      ovf_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      ovf_q <= ovf_d;
    end
  end
endmodule
`default_nettype wire

//--- transfer_and_position_error_reporter.sv
// Purpose: Classify transfer, save, teach and position faults into codes
// Assumes: Request strobes are one-cycle pulses from clk logic
// Notes: Servo warning pins are asynchronous and synchronised here
// Behaviour
// - Bad write word count gives 8221
// - Bad host source area gives 8222
// - Bad host start word gives 8223
// - Bad unit destination area gives 8224
// - Setup-only write outside setup gives 8226
// - Such writes never reach the parameter
// - Failed or stalled write gives 8227
// - Invalid slave parameter data gives 8228
// - Bus error without messaging gives 8229
// - Slave in error gives 822A
// - Save during backup refused with 8230
// - Data check warning 90/91/92 by class
// - Warning low byte holds parameter offset
// - Servo warning gives axis code D00F
// - Command position out of range gives E027
// - Feedback position out of range gives E028
// - Bad teaching address gives ED00
// - Teaching during save refused with ED01
// - Teaching overflowed axis gives ED02
// - Positions are signed 32-bit values
// - Error overwrites a pending warning
`timescale 1ns/1ns
`default_nettype none
module transfer_and_position_error_reporter #(
  parameter int N_AXES = 4,
  parameter int WR_TIMEOUT_CYC = xfer_err_pkg::WR_TIMEOUT_CYCLES,
  parameter logic [15:0] MAX_WORDS = 16'h0100,
  parameter logic [7:0] N_SRC_AREAS = 8'h05,
  parameter logic [15:0] MAX_SRC_WORD = 16'h7fff,
  parameter logic [7:0] N_DST_AREAS = 8'h04,
  parameter logic [15:0] MAX_DST_WORD = 16'h0fff,
  parameter logic [15:0] MAX_TEACH_ADDR = 16'h03ff
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_req,
  input wire xfer_err_pkg::wr_req_t wr_info,
  input wire logic setup_phase,
  input wire logic wr_done,
  input wire logic wr_fail,
  input wire logic bus_err,
  input wire logic msg_en,
  input wire logic slave_err,
  input wire logic save_req,
  input wire logic save_done,
  input wire logic backup_busy,
  input wire logic teach_req,
  input wire logic [15:0] teach_addr,
  input wire logic [$clog2(N_AXES)-1:0] teach_axis,
  input wire logic err_reset,
  input wire logic warn_reset,
  input wire logic [N_AXES-1:0] servo_warn,
  input wire logic [N_AXES-1:0] cmd_step_v,
  input wire logic [N_AXES-1:0][31:0] cmd_step,
  input wire logic [N_AXES-1:0] fb_step_v,
  input wire logic [N_AXES-1:0][31:0] fb_step,
  input wire logic [N_AXES-1:0] origin_done,
  input wire logic [N_AXES-1:0] pos_preset,
  input wire logic [N_AXES-1:0] fb_preset,
  input wire logic [N_AXES-1:0][31:0] preset_val,
  output logic [15:0] unit_code_q,
  output logic unit_err_q,
  output logic [N_AXES-1:0][15:0] axis_code_q,
  output logic [15:0] task_code_q,
  output logic write_commit_q,
  output logic write_busy_q,
  output logic save_busy_q,
  output logic teach_ok_q,
  output logic [N_AXES-1:0][31:0] cmd_pos_q,
  output logic [N_AXES-1:0][31:0] fb_pos_q,
  output logic [N_AXES-1:0] cmd_ovf_q,
  output logic [N_AXES-1:0] fb_ovf_q
);
  import xfer_err_pkg::*;

  // ========================================
  // Write request checks in priority order
  function automatic logic [15:0] check_write(input wr_req_t r);
    logic [15:0] c;
    c = C_NONE;
    if (r.words == 16'h0000 || r.words > MAX_WORDS) begin
      c = C_WORDS;
    end else if (r.src_area >= N_SRC_AREAS) begin
      c = C_SRC_AREA;
    end else if (r.src_word > MAX_SRC_WORD) begin
      c = C_SRC_WORD;
    end else if (r.dst_area >= N_DST_AREAS) begin
      c = C_DST_AREA;
    end else if (r.dst_word > MAX_DST_WORD) begin
      c = C_DST_WORD;
    end else if (r.slave_param && bus_err && !msg_en) begin
      c = C_BUS_ERR;
    end else if (r.slave_param && slave_err) begin
      c = C_SLV_ERR;
    end else if (r.slave_param && !r.data_ok) begin
      c = C_SLV_DATA;
    end else if (r.setup_eff && !setup_phase) begin
      c = C_SETUP_ONLY;
    end else if (!r.data_ok) begin
      c = {r.pclass == PCLASS_COMMON ? C_CHK_COMMON :
           r.pclass == PCLASS_AXIS ? C_CHK_AXIS : C_CHK_TASK,
           r.poffset};
    end
    return c;
  endfunction

  // Warning codes are those of the data check class
  function automatic logic is_error(input logic [15:0] c);
    return c[15:12] != 4'h9;
  endfunction

  // ========================================
  // Servo warning input synchroniser
  logic [N_AXES-1:0] sw1_q, sw2_q, sw3_q, swf_q, swf_d;
  always_comb begin
    swf_d = swf_q;
    for (int i = 0; i < N_AXES; i++) begin
      if (sw2_q[i] == sw3_q[i]) begin
        swf_d[i] = sw3_q[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sw1_q <= '0;
      sw2_q <= '0;
      sw3_q <= '0;
      swf_q <= '0;
    end else begin
      sw1_q <= servo_warn;
      sw2_q <= sw1_q;
      sw3_q <= sw2_q;
      swf_q <= swf_d;
    end
  end

  // ========================================
  // Present position trackers
  logic [N_AXES-1:0] cmd_clr;
  assign cmd_clr = origin_done | pos_preset;
  for (genvar g = 0; g < N_AXES; g++) begin : g_axis
    position_tracker u_cmd (
      .clk(clk), .rst(rst), .step_v(cmd_step_v[g]), .step(cmd_step[g]),
      .clr(cmd_clr[g]), .clr_val(preset_val[g]),
      .pos_q(cmd_pos_q[g]), .ovf_q(cmd_ovf_q[g]));
    position_tracker u_fb (
      .clk(clk), .rst(rst), .step_v(fb_step_v[g]), .step(fb_step[g]),
      .clr(fb_preset[g]), .clr_val(preset_val[g]),
      .pos_q(fb_pos_q[g]), .ovf_q(fb_ovf_q[g]));
  end

  // ========================================
  // Write transfer sequencer and unit code
  wr_state_t ws_q, ws_d;
  logic [31:0] wcnt_q, wcnt_d;
  logic [15:0] unit_code_d, wchk;
  logic unit_err_d, commit_d, save_busy_d, take;
  logic [15:0] ev_code;

  always_comb begin
    ws_d = ws_q;
    wcnt_d = wcnt_q;
    commit_d = 1'b0;
    save_busy_d = save_busy_q;
    unit_code_d = unit_code_q;
    unit_err_d = unit_err_q;
    ev_code = C_NONE;
    wchk = check_write(wr_info);
    take = wr_req && ws_q == WS_IDLE;
    if (take) begin
      if (wchk == C_NONE) begin
        ws_d = WS_BUSY;
        wcnt_d = 32'h0000_0000;
      end else begin
        ev_code = wchk;
      end
    end else if (ws_q == WS_BUSY) begin
      wcnt_d = wcnt_q + 32'h0000_0001;
      if (wr_done) begin
        ws_d = WS_IDLE;
        commit_d = 1'b1;
      end else if (wr_fail || wcnt_q >= 32'(WR_TIMEOUT_CYC - 1)) begin
        ws_d = WS_IDLE;
        ev_code = C_WR_TIMEOUT;
      end
    end
    if (save_busy_q && save_done) begin
      save_busy_d = 1'b0;
    end
    if (save_req && !save_busy_q) begin
      if (backup_busy) begin
        ev_code = C_SAVE_BLOCK;
      end else begin
        save_busy_d = 1'b1;
      end
    end
    if ((err_reset && unit_err_q) || (warn_reset && !unit_err_q)) begin
      unit_code_d = C_NONE;
      unit_err_d = 1'b0;
    end
    if (ev_code != C_NONE && (is_error(ev_code) || !unit_err_d)) begin
      unit_code_d = ev_code;
      unit_err_d = is_error(ev_code);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ws_q <= WS_IDLE;
      wcnt_q <= 32'h0000_0000;
      unit_code_q <= C_NONE;
      unit_err_q <= 1'b0;
      write_commit_q <= 1'b0;
      write_busy_q <= 1'b0;
      save_busy_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      wcnt_q <= wcnt_d;
      unit_code_q <= unit_code_d;
      unit_err_q <= unit_err_d;
      write_commit_q <= commit_d;
      write_busy_q <= ws_d == WS_BUSY;
      save_busy_q <= save_busy_d;
    end
  end

  // ========================================
  // Axis codes
  logic [N_AXES-1:0][15:0] axis_code_d;
  logic [N_AXES-1:0] sw_stk_q, sw_stk_d, swf_old_q;
  always_comb begin
    axis_code_d = axis_code_q;
    sw_stk_d = sw_stk_q;
    for (int i = 0; i < N_AXES; i++) begin
      if (warn_reset) begin
        sw_stk_d[i] = 1'b0;
        axis_code_d[i] = C_NONE;
      end
      if (swf_q[i] && !swf_old_q[i]) begin
        sw_stk_d[i] = 1'b1;
      end
      if (cmd_ovf_q[i]) begin
        axis_code_d[i] = C_CMD_OVF;
      end else if (fb_ovf_q[i]) begin
        axis_code_d[i] = C_FB_OVF;
      end else if (sw_stk_d[i]) begin
        axis_code_d[i] = C_SERVO_WARN;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      axis_code_q <= '0;
      sw_stk_q <= '0;
      swf_old_q <= '0;
    end else begin
      axis_code_q <= axis_code_d;
      sw_stk_q <= sw_stk_d;
      swf_old_q <= swf_q;
    end
  end

  // ========================================
  // Teaching checks and task code
  logic [15:0] task_code_d;
  logic teach_ok_d, tovf_q, tovf_d;
  logic [$clog2(N_AXES)-1:0] tax_q, tax_d;
  always_comb begin
    task_code_d = task_code_q;
    teach_ok_d = 1'b0;
    tovf_d = tovf_q;
    tax_d = tax_q;
    if (err_reset && !tovf_q) begin
      task_code_d = C_NONE;
    end
    if (tovf_q && cmd_clr[tax_q]) begin
      tovf_d = 1'b0;
      task_code_d = C_NONE;
    end
    if (teach_req) begin
      if (teach_addr > MAX_TEACH_ADDR) begin
        task_code_d = C_TEACH_ADDR;
      end else if (save_busy_q) begin
        task_code_d = C_TEACH_BLOCK;
      end else if (cmd_ovf_q[teach_axis]) begin
        tovf_d = 1'b1;
        tax_d = teach_axis;
      end else begin
        teach_ok_d = 1'b1;
      end
    end
    if (tovf_d) begin
      task_code_d = C_TEACH_OVF;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      task_code_q <= C_NONE;
      teach_ok_q <= 1'b0;
      tovf_q <= 1'b0;
      tax_q <= '0;
    end else begin
      task_code_q <= task_code_d;
      teach_ok_q <= teach_ok_d;
      tovf_q <= tovf_d;
      tax_q <= tax_d;
    end
  end

  // ========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take;
    wr_req && !write_busy_q && !save_req;
  endsequence
  sequence s_idle_rst;
    !err_reset && !warn_reset;
  endsequence
  AST_WORDS: assert property (s_take ##0 wr_info.words == 16'h0000
    |=> unit_code_q == C_WORDS && unit_err_q)
    else $error("word count fault not reported");
  AST_SRC_AREA: assert property (s_take ##0 wr_info.words == 16'h0001
    ##0 wr_info.src_area >= N_SRC_AREAS |=> unit_code_q == C_SRC_AREA)
    else $error("source area fault not reported");
  AST_NO_COMMIT: assert property (s_take ##0 check_write(wr_info) != C_NONE
    |=> !write_busy_q ##1 !write_commit_q)
    else $error("rejected write went ahead");
  AST_TIMEOUT: assert property (write_busy_q && !wr_done && !wr_fail
    && wcnt_q == 32'(WR_TIMEOUT_CYC - 1) && !save_req
    |=> unit_code_q == C_WR_TIMEOUT && !write_busy_q)
    else $error("write timeout not reported");
  AST_SAVE: assert property (save_req && !save_busy_q && backup_busy
    |=> unit_code_q == C_SAVE_BLOCK)
    else $error("blocked save not reported");
  AST_CMD_OVF: assert property ($rose(cmd_ovf_q[0])
    |=> axis_code_q[0] == C_CMD_OVF)
    else $error("command overflow code missing");
  AST_OVF_HOLD: assert property (cmd_ovf_q[0] && !cmd_clr[0]
    |=> cmd_ovf_q[0])
    else $error("overflow cleared without preset");
  AST_TEACH_ADDR: assert property (teach_req && teach_addr > MAX_TEACH_ADDR
    |=> task_code_q == C_TEACH_ADDR && !teach_ok_q)
    else $error("teach address fault not reported");
  AST_TEACH_SAVE: assert property (teach_req
    && teach_addr <= MAX_TEACH_ADDR && save_busy_q
    |=> task_code_q == C_TEACH_BLOCK)
    else $error("teach during save not refused");
  AST_ERR_KEEP: assert property (unit_err_q ##0 s_idle_rst
    ##0 !save_req |=> unit_err_q)
    else $error("warning replaced an error");
endmodule
`default_nettype wire

//--- xfer_host_model.sv
// Purpose: Host side that answers accepted data writes
// Assumes: busy is the reporter's write busy level
// Notes: Mode 0 prompt, 1 slow, 2 fail, 3 never answers
`timescale 1ns/1ns
`default_nettype none
module xfer_host_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic [1:0] mode,
  output logic wr_done,
  output logic wr_fail
);
  int n;
  initial begin
    wr_done = 1'b0;
    wr_fail = 1'b0;
    n = 0;
  end
  // ========================================
  // One answer pulse after a mode-dependent wait
  always @(negedge clk) begin
    wr_done <= 1'b0;
    wr_fail <= 1'b0;
    if (!busy || wr_done || wr_fail) begin
      n <= 0;
    end else begin
      n <= n + 1;
      if (n == ((mode == 2'h1) ? 6 : 1)) begin
        if (mode == 2'h2) wr_fail <= 1'b1;
        else if (mode != 2'h3) wr_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the error reporter
// Assumes: Inputs driven at the falling edge
// Notes: Write timeout shortened to 16 cycles
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import xfer_err_pkg::*;
  typedef struct packed {
    wr_req_t r;
    logic be;
    logic se;
    logic [15:0] exp;
  } row_t;
  logic clk = 1'b0;
  logic rst, wr_req, setup_phase, wr_done, wr_fail, bus_err, msg_en;
  logic slave_err, save_req, save_done, backup_busy, teach_req;
  logic err_reset, warn_reset, unit_err_q, write_commit_q, write_busy_q;
  logic save_busy_q, teach_ok_q, ok;
  wr_req_t wr_info, base, rq;
  logic [15:0] teach_addr, unit_code_q, task_code_q;
  logic [1:0] teach_axis, host_mode;
  logic [3:0] servo_warn, cmd_step_v, fb_step_v, origin_done, pos_preset;
  logic [3:0] fb_preset, cmd_ovf_q, fb_ovf_q;
  logic [3:0][31:0] cmd_step, fb_step, preset_val, cmd_pos_q, fb_pos_q;
  logic [3:0][15:0] axis_code_q;
  row_t rows[$];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // ========================================
  // Design and host model
  transfer_and_position_error_reporter #(.WR_TIMEOUT_CYC(16)) dut (
    .clk, .rst, .wr_req, .wr_info, .setup_phase, .wr_done, .wr_fail,
    .bus_err, .msg_en, .slave_err, .save_req, .save_done, .backup_busy,
    .teach_req, .teach_addr, .teach_axis, .err_reset, .warn_reset,
    .servo_warn, .cmd_step_v, .cmd_step, .fb_step_v, .fb_step,
    .origin_done, .pos_preset, .fb_preset, .preset_val, .unit_code_q,
    .unit_err_q, .axis_code_q, .task_code_q, .write_commit_q,
    .write_busy_q, .save_busy_q, .teach_ok_q, .cmd_pos_q, .fb_pos_q,
    .cmd_ovf_q, .fb_ovf_q);
  xfer_host_model host (.clk(clk), .busy(write_busy_q), .mode(host_mode),
    .wr_done(wr_done), .wr_fail(wr_fail));
  // ========================================
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  // ========================================
  // Tasks
  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clr_codes();
    @(negedge clk);
    err_reset = 1'b1;
    warn_reset = 1'b1;
    tick(1);
    err_reset = 1'b0;
    warn_reset = 1'b0;
    tick(1);
  endtask
  task automatic send(input wr_req_t r);
    @(negedge clk);
    wr_info = r;
    wr_req = 1'b1;
    tick(1);
    wr_req = 1'b0;
    tick(1);
  endtask
  task automatic teach(input logic [15:0] a);
    @(negedge clk);
    teach_addr = a;
    teach_req = 1'b1;
    ok = 1'b0;
    tick(1);
    teach_req = 1'b0;
    repeat (3) begin
      ok = ok | teach_ok_q;
      tick(1);
    end
  endtask
  task automatic wait_code(input logic [15:0] e);
    for (int i = 0; i < 40 && unit_code_q !== e; i++) tick(1);
    chk("unit_code", e, unit_code_q);
  endtask
  // ========================================
  // Main sequence
  initial begin
    {rst, wr_req, setup_phase, bus_err, slave_err, save_req} = '0;
    {save_done, backup_busy, teach_req, err_reset, warn_reset} = '0;
    {teach_addr, teach_axis, host_mode, servo_warn, cmd_step_v} = '0;
    {fb_step_v, origin_done, pos_preset, fb_preset} = '0;
    {cmd_step, fb_step, preset_val} = '0;
    msg_en = 1'b1;
    rst = 1'b1;
    base = '{16'h0100, 8'h04, 16'h7fff, 8'h03, 16'h0fff, 1'b0, 1'b0,
             PCLASS_COMMON, 8'h00, 1'b1};
    wr_info = base;
    tick(5);
    rst = 1'b0;
    tick(1);
    chk("unit_code", 0, unit_code_q);
    chk("axis_code", 0, axis_code_q[0]);
    chk("task_code", 0, task_code_q);
    // Rejected writes, one row per code, two for the word count
    rq = base; rq.words = 16'h0000; rows.push_back({rq, 2'b00, C_WORDS});
    rq = base; rq.words = 16'h0101; rows.push_back({rq, 2'b00, C_WORDS});
    rq = base; rq.src_area = 8'h05; rows.push_back({rq, 2'b00, C_SRC_AREA});
    rq = base; rq.src_word = 16'h8000; rows.push_back({rq, 2'b00, C_SRC_WORD});
    rq = base; rq.dst_area = 8'h04; rows.push_back({rq, 2'b00, C_DST_AREA});
    rq = base; rq.dst_word = 16'h1000; rows.push_back({rq, 2'b00, C_DST_WORD});
    rq = base; rq.slave_param = 1'b1; rows.push_back({rq, 2'b10, C_BUS_ERR});
    rows.push_back({rq, 2'b01, C_SLV_ERR});
    rq.data_ok = 1'b0; rows.push_back({rq, 2'b00, C_SLV_DATA});
    rq = base; rq.setup_eff = 1'b1; rows.push_back({rq, 2'b00, C_SETUP_ONLY});
    rq = base; rq.data_ok = 1'b0; rows.push_back({rq, 2'b00, 16'h9000});
    rq.pclass = 2'h1; rq.poffset = 8'hff; rows.push_back({rq, 2'b00, 16'h91ff});
    rq.pclass = 2'h2; rq.poffset = 8'h37; rows.push_back({rq, 2'b00, 16'h9237});
    foreach (rows[i]) begin
      clr_codes();
      bus_err = rows[i].be;
      msg_en = !rows[i].be;
      slave_err = rows[i].se;
      send(rows[i].r);
      chk("unit_code", rows[i].exp, unit_code_q);
      chk("write_busy", 0, write_busy_q);
    end
    {bus_err, slave_err, msg_en} = 3'b001;
    // Accepted writes: prompt, slow, and setup-only inside setup
    for (int k = 0; k < 3; k++) begin
      clr_codes();
      host_mode = (k == 1) ? 2'h1 : 2'h0;
      setup_phase = (k == 2);
      rq = base;
      rq.setup_eff = (k == 2);
      send(rq);
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
        ok = write_commit_q;
        tick(1);
      end
      chk("commit", 1, ok);
      chk("unit_code", 0, unit_code_q);
    end
    setup_phase = 1'b0;
    // Failed and stalled writes
    for (int k = 2; k < 4; k++) begin
      clr_codes();
      host_mode = k[1:0];
      send(base);
      wait_code(C_WR_TIMEOUT);
    end
    // Error overwrites warning, warning never overwrites error
    clr_codes();
    rq = base;
    rq.data_ok = 1'b0;
    send(rq);
    rq.words = 16'h0000;
    send(rq);
    chk("unit_code", C_WORDS, unit_code_q);
    chk("unit_err", 1, unit_err_q);
    rq = base;
    rq.data_ok = 1'b0;
    send(rq);
    chk("unit_code", C_WORDS, unit_code_q);
    // Save and teaching interplay
    clr_codes();
    backup_busy = 1'b1;
    save_req = 1'b1;
    tick(1);
    save_req = 1'b0;
    tick(2);
    chk("unit_code", C_SAVE_BLOCK, unit_code_q);
    backup_busy = 1'b0;
    clr_codes();
    save_req = 1'b1;
    tick(1);
    save_req = 1'b0;
    tick(1);
    chk("save_busy", 1, save_busy_q);
    teach(16'h0000);
    chk("task_code", C_TEACH_BLOCK, task_code_q);
    save_done = 1'b1;
    tick(1);
    save_done = 1'b0;
    clr_codes();
    teach(16'h0400);
    chk("task_code", C_TEACH_ADDR, task_code_q);
    clr_codes();
    teach(16'h03ff);
    chk("teach_ok", 1, ok);
    // Command position overflow at the top of the range
    preset_val[0] = 32'h7fffffff;
    origin_done[0] = 1'b1;
    tick(1);
    origin_done[0] = 1'b0;
    cmd_step[0] = 32'h00000001;
    cmd_step_v[0] = 1'b1;
    tick(1);
    cmd_step_v[0] = 1'b0;
    clr_codes();
    chk("cmd_ovf", 1, cmd_ovf_q[0]);
    chk("cmd_pos", 32'h7fffffff, cmd_pos_q[0]);
    chk("axis_code", C_CMD_OVF, axis_code_q[0]);
    teach(16'h0001);
    chk("task_code", C_TEACH_OVF, task_code_q);
    origin_done[0] = 1'b1;
    tick(1);
    origin_done[0] = 1'b0;
    tick(2);
    chk("cmd_ovf", 0, cmd_ovf_q[0]);
    chk("task_code", 0, task_code_q);
    // Feedback underflow at the bottom of the range
    preset_val[0] = 32'h80000000;
    fb_preset[0] = 1'b1;
    tick(1);
    fb_preset[0] = 1'b0;
    fb_step[0] = 32'hffffffff;
    fb_step_v[0] = 1'b1;
    tick(1);
    fb_step_v[0] = 1'b0;
    pos_preset[0] = 1'b1;
    tick(1);
    pos_preset[0] = 1'b0;
    clr_codes();
    chk("fb_ovf", 1, fb_ovf_q[0]);
    chk("fb_pos", 32'h80000000, fb_pos_q[0]);
    chk("axis_code", C_FB_OVF, axis_code_q[0]);
    fb_preset[0] = 1'b1;
    tick(1);
    fb_preset[0] = 1'b0;
    tick(2);
    chk("fb_ovf", 0, fb_ovf_q[0]);
    // Servo warning on axis 1
    servo_warn[1] = 1'b1;
    for (int i = 0; i < 12 && axis_code_q[1] !== C_SERVO_WARN; i++) tick(1);
    chk("axis_code", C_SERVO_WARN, axis_code_q[1]);
    clr_codes();
    chk("axis_code", 0, axis_code_q[1]);
    summarize();
  end
endmodule
`default_nettype wire
